/* File: sts_pkg.sv */
// Constants and types for the scan trigger sequencer
// How it works
// RULE_01 - Sweep visits listed slots one to eight, ascending, skipping absent ones
// RULE_02 - A new initiate discards all readings of earlier scans
// RULE_03 - Empty list: initiate runs one internal meter reading, no channel switched
// RULE_04 - Host abort ends the scan in progress
// RULE_05 - Sweep start comes from timer, bus/key, initiate, external pulse or alarm
// RULE_06 - Timer period runs trigger to trigger; short periods sweep back to back
// RULE_07 - Interval programmable zero to 359,999 seconds in 1 ms steps
// RULE_08 - Sweeps repeat until abort or accepted triggers equal trigger count
// RULE_09 - Configure/measure command forces interval zero and count one
// RULE_10 - Factory reset zeroes interval; preset and card reset leave it
// RULE_11 - Each reading gets gain/offset scaling and limit check before storing
// RULE_12 - Bus mode waits for key press or remote trigger per sweep
// RULE_13 - Bus trigger rejected unless sequencer waits for trigger
// RULE_14 - Alarm mode starts a sweep when monitored reading crosses enabled limit
// RULE_15 - Digital alarms on pattern or pattern change, totalizer on count
// RULE_16 - Setting chooses single sweep or continuous sweeping on alarm
// RULE_17 - Monitored channel may be off-list but must be configured
// RULE_18 - External mode: one sweep per low-going pulse
// RULE_19 - One early external trigger held pending, later ones dropped silently
// RULE_20 - Readings accumulate across sweeps until count reached or abort
// RULE_21 - Trigger count one to 500,000 or continuous
// RULE_22 - Abort ends reading, keeps memory, no resume without new initiate
// RULE_23 - Memory overflow sets flag and overwrites oldest readings
// RULE_24 - Timer counts ms ticks and restarts on each accepted trigger
// RULE_25 - External input synchronised and falling edge detected before latch
package sts_pkg;
  localparam int STS_CLK_NS = 10;
  localparam int STS_TICK_MS = 1;
  localparam int STS_MS_CYC = STS_TICK_MS * 1000000 / STS_CLK_NS;
  localparam int STS_SLOTS = 8;
  localparam int STS_INT_MAX_S = 359999;
  localparam logic [28:0] STS_INT_MAX_MS = 29'(STS_INT_MAX_S * 1000);
  localparam logic [18:0] STS_TCNT_MAX = 19'h7A120;
  localparam logic [18:0] STS_TCNT_RST = 19'h00001;
  localparam logic [28:0] STS_INT_RST = 29'h0;
  localparam logic [15:0] STS_GAIN_RST = 16'h0100;
  localparam logic [15:0] STS_OFFS_RST = 16'h0000;
  localparam logic [3:0] STS_A_CTRL = 4'h0;
  localparam logic [3:0] STS_A_CFG = 4'h1;
  localparam logic [3:0] STS_A_LIST = 4'h2;
  localparam logic [3:0] STS_A_INTV = 4'h3;
  localparam logic [3:0] STS_A_TCNT = 4'h4;
  localparam logic [3:0] STS_A_STAT = 4'h5;
  localparam logic [3:0] STS_A_LIM = 4'h6;
  localparam logic [3:0] STS_A_SCALE = 4'h7;
  localparam logic [3:0] STS_A_MIDX = 4'h8;
  localparam logic [3:0] STS_A_MDATA = 4'h9;
  localparam logic [3:0] STS_A_MCNT = 4'hA;
  localparam int STS_C_INIT = 0;
  localparam int STS_C_ABORT = 1;
  localparam int STS_C_BUSTRG = 2;
  localparam int STS_C_KEY = 3;
  localparam int STS_C_CONF = 4;
  localparam int STS_C_FRST = 5;
  localparam int STS_C_PRESET = 6;
  localparam int STS_C_CARD = 7;
  localparam int STS_TCNT_CONT = 31;
  localparam int STS_S_REJ = 4;
  localparam int STS_S_OVF = 5;
  localparam logic [2:0] STS_SRC_TIMER = 3'h0;
  localparam logic [2:0] STS_SRC_BUS = 3'h1;
  localparam logic [2:0] STS_SRC_SOFT = 3'h2;
  localparam logic [2:0] STS_SRC_EXT = 3'h3;
  localparam logic [2:0] STS_SRC_ALARM = 3'h4;
  localparam logic [1:0] STS_ALM_LIMIT = 2'h0;
  localparam logic [1:0] STS_ALM_PAT = 2'h1;
  localparam logic [1:0] STS_ALM_CHG = 2'h2;
  localparam logic [1:0] STS_ALM_COUNT = 2'h3;
  typedef struct packed {
    logic [1:0] alm_kind;
    logic [2:0] mon_chan;
    logic       monitor_enable;
    logic       alm_cont;
    logic [2:0] src;
  } sts_cfg_type;
  localparam sts_cfg_type STS_CFG_RST = '0;
  typedef struct packed {
    logic        alarm;
    logic        internal;
    logic [2:0]  chan;
    logic [15:0] value;
  } sts_rd_type;
  typedef enum logic [1:0] {STS_IDLE, STS_WAITT, STS_MEAS, STS_FIN} sts_state_type;
endpackage

/* File: sts_scan_trigger_sequencer.sv */
// Scan trigger sequencer with Avalon-MM register slave
`timescale 1ns/100ps
`default_nettype none
module sts_scan_trigger_sequencer
  import sts_pkg::*;
#(
  parameter int DEPTH    = 16,
  parameter int TICK_CYC = STS_MS_CYC
)(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        ext_trig_b,
  input  wire logic        meas_done,
  input  wire logic [15:0] meas_data,
  input  wire logic        mon_valid,
  input  wire logic [15:0] mon_data,
  output logic             chan_req,
  output logic [2:0]       chan_sel,
  output logic             internal_meas,
  output logic             meas_abort,
  output logic             scanning,
  output logic             waiting_trig,
  output logic             first_alarm_output
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("DEPTH must be a power of two, at least 2");
    if (TICK_CYC < 1)
      $error("TICK_CYC must be positive");
  end

  // Lowest listed slot at or above start, 4'h8 when none
  function automatic logic [3:0] next_slot(input logic [7:0] m, input logic [3:0] s);
    logic [3:0] r;
    r = 4'h8;
    for (int i = STS_SLOTS - 1; i >= 0; i--)
      if (m[i] && 4'(i) >= s)
        r = 4'(i);
    return r;
  endfunction

  logic rst_q1_reg, rst_sync_b;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_q1_reg <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_q1_reg <= 1'b1;
      rst_sync_b <= rst_q1_reg;
    end
  end

  sts_state_type st_reg;
  sts_cfg_type   cfg_reg;
  logic [7:0]  list_reg, conf_reg;
  logic [28:0] intv_reg, elap_reg;
  logic [18:0] tcnt_reg, acc_reg;
  logic        cont_reg, rej_reg, ovf_reg;
  logic [15:0] lim_reg, gain_reg, offs_reg, mprev_reg;
  logic [AW-1:0] midx_reg, wptr_reg;
  logic [AW:0]   mcnt_reg;
  logic        wait_reg;
  logic [31:0] rdat_reg;
  logic [2:0]  cur_reg;
  logic        req_reg, int_reg, abt_reg, alm_out_reg;
  logic        ext1_reg, ext2_reg, ext3_reg, pend_reg;
  logic        almp_reg, almrun_reg, mprev_ok_reg;
  logic [$clog2(TICK_CYC+1)-1:0] div_reg;
  logic        tick;
  sts_rd_type  mem [DEPTH];

  // Avalon handshake: request seen, then one cycle with waitrequest low
  wire acc_cyc = (avs_read || avs_write) && !wait_reg;
  wire wr_cyc = avs_write && !wait_reg;
  wire [3:0] widx = avs_address[5:2];
  wire ctl_wr = wr_cyc && widx == STS_A_CTRL;
  wire init_p = ctl_wr && avs_writedata[STS_C_INIT];
  wire abort_p = ctl_wr && avs_writedata[STS_C_ABORT];
  wire bus_p = ctl_wr && (avs_writedata[STS_C_BUSTRG] || avs_writedata[STS_C_KEY]);
  wire conf_p = ctl_wr && avs_writedata[STS_C_CONF];
  wire frst_p = ctl_wr && avs_writedata[STS_C_FRST];

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b)
      wait_reg <= 1'b1;
    else if (!wait_reg)
      wait_reg <= 1'b1;
    else if (avs_read || avs_write)
      wait_reg <= 1'b0;
  end

  wire [AW-1:0] phys = wptr_reg - mcnt_reg[AW-1:0] + midx_reg;
  wire [31:0] stat_word = {24'h0, 2'b0, ovf_reg, rej_reg, 1'b0, pend_reg, st_reg};

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b)
      rdat_reg <= 32'h0;
    else if ((avs_read || avs_write) && wait_reg) begin
      unique case (widx)
        STS_A_CFG: rdat_reg <= 32'(cfg_reg);
        STS_A_LIST: rdat_reg <= {16'h0, conf_reg, list_reg};
        STS_A_INTV: rdat_reg <= {3'h0, intv_reg};
        STS_A_TCNT: rdat_reg <= {cont_reg, 12'h0, tcnt_reg};
        STS_A_STAT: rdat_reg <= stat_word;
        STS_A_LIM: rdat_reg <= {16'h0, lim_reg};
        STS_A_SCALE: rdat_reg <= {offs_reg, gain_reg};
        STS_A_MIDX: rdat_reg <= 32'(midx_reg);
        STS_A_MDATA: rdat_reg <= 32'(mem[phys]);
        STS_A_MCNT: rdat_reg <= 32'(mcnt_reg);
        default: rdat_reg <= 32'h0;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cfg_reg <= STS_CFG_RST;
      list_reg <= 8'h00;
      conf_reg <= 8'h00;
      lim_reg <= 16'h0000;
      gain_reg <= STS_GAIN_RST;
      offs_reg <= STS_OFFS_RST;
      midx_reg <= '0;
    end else if (frst_p) begin
      cfg_reg <= STS_CFG_RST;
      list_reg <= 8'h00;
      gain_reg <= STS_GAIN_RST;
      offs_reg <= STS_OFFS_RST;
    end else if (wr_cyc) begin
      unique case (widx)
        STS_A_CFG: cfg_reg <= sts_cfg_type'(avs_writedata[9:0]);
        STS_A_LIST: {conf_reg, list_reg} <= avs_writedata[15:0];
        STS_A_LIM: lim_reg <= avs_writedata[15:0];
        STS_A_SCALE: {offs_reg, gain_reg} <= avs_writedata;
        STS_A_MIDX: midx_reg <= avs_writedata[AW-1:0];
        default: ;
      endcase
    end
  end

  // RULE_07 RULE_09 RULE_10 interval and count
  // Preset and card reset commands deliberately touch neither
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      intv_reg <= STS_INT_RST;
      tcnt_reg <= STS_TCNT_RST;
      cont_reg <= 1'b0;
    end else if (conf_p || frst_p) begin
      intv_reg <= STS_INT_RST;
      tcnt_reg <= STS_TCNT_RST;
      cont_reg <= 1'b0;
    end else if (wr_cyc && widx == STS_A_INTV) begin
      intv_reg <= avs_writedata[28:0] > STS_INT_MAX_MS ? STS_INT_MAX_MS : avs_writedata[28:0];
    end else if (wr_cyc && widx == STS_A_TCNT) begin
      // RULE_21 count range
      cont_reg <= avs_writedata[STS_TCNT_CONT];
      if (avs_writedata[18:0] == 19'h0)
        tcnt_reg <= STS_TCNT_RST;
      else if (avs_writedata[18:0] > STS_TCNT_MAX)
        tcnt_reg <= STS_TCNT_MAX;
      else
        tcnt_reg <= avs_writedata[18:0];
    end
  end

  // RULE_25 external trigger synchroniser and edge
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      ext1_reg <= 1'b1;
      ext2_reg <= 1'b1;
      ext3_reg <= 1'b1;
    end else begin
      ext1_reg <= ext_trig_b;
      ext2_reg <= ext1_reg;
      ext3_reg <= ext2_reg;
    end
  end
  wire ext_fall = ext3_reg && !ext2_reg;

  wire running = st_reg != STS_IDLE;
  wire src_ext = cfg_reg.src == STS_SRC_EXT;
  wire src_alm = cfg_reg.src == STS_SRC_ALARM;
  wire in_wait = st_reg == STS_WAITT;

  // RULE_17 monitoring needs a configured channel
  wire mon_ok = cfg_reg.monitor_enable && conf_reg[cfg_reg.mon_chan];
  logic alm_hit;
  // RULE_14 RULE_15 alarm kinds on the monitored channel
  always_comb begin
    unique case (cfg_reg.alm_kind)
      STS_ALM_LIMIT: alm_hit = mprev_ok_reg && mon_data > lim_reg && mprev_reg <= lim_reg;
      STS_ALM_PAT: alm_hit = mon_data == lim_reg;
      STS_ALM_CHG: alm_hit = mprev_ok_reg && mon_data != mprev_reg;
      STS_ALM_COUNT: alm_hit = mprev_ok_reg && mon_data >= lim_reg && mprev_reg < lim_reg;
    endcase
  end
  wire alm_ev = mon_valid && mon_ok && alm_hit;

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mprev_reg <= 16'h0;
      mprev_ok_reg <= 1'b0;
      alm_out_reg <= 1'b0;
    end else begin
      alm_out_reg <= alm_ev;
      if (mon_valid && mon_ok) begin
        mprev_reg <= mon_data;
        mprev_ok_reg <= 1'b1;
      end else if (!mon_ok) begin
        mprev_ok_reg <= 1'b0;
      end
    end
  end

  // RULE_24 millisecond tick and trigger-aligned elapsed time
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b)
      div_reg <= '0;
    else if (tick)
      div_reg <= '0;
    else
      div_reg <= div_reg + 1'b1;
  end
  assign tick = div_reg == ($bits(div_reg))'(TICK_CYC - 1);

  wire timer_due = elap_reg >= intv_reg;
  logic go;
  // RULE_05 trigger source select
  always_comb begin
    unique case (cfg_reg.src)
      // RULE_06 due stays set, so late sweeps restart at once
      STS_SRC_TIMER: go = timer_due;
      // RULE_12 key or remote trigger
      STS_SRC_BUS: go = bus_p;
      STS_SRC_SOFT: go = 1'b1;
      // RULE_18 one sweep per pulse
      STS_SRC_EXT: go = pend_reg;
      STS_SRC_ALARM: go = almp_reg || almrun_reg;
      default: go = 1'b0;
    endcase
  end
  wire accept = in_wait && go && !abort_p;

  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b)
      elap_reg <= 29'h0;
    else if (accept)
      elap_reg <= 29'h0;
    else if (init_p && !running)
      elap_reg <= STS_INT_MAX_MS;
    else if (tick && elap_reg != STS_INT_MAX_MS)
      elap_reg <= elap_reg + 29'h1;
  end

  // RULE_19 one-deep pending external trigger
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b)
      pend_reg <= 1'b0;
    else if (ext_fall && running && src_ext)
      pend_reg <= 1'b1;
    else if (accept || !running)
      pend_reg <= 1'b0;
  end

  // RULE_16 single sweep per alarm or continuous after first
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      almp_reg <= 1'b0;
      almrun_reg <= 1'b0;
    end else begin
      if (alm_ev && running && src_alm)
        almp_reg <= 1'b1;
      else if (accept || !running)
        almp_reg <= 1'b0;
      if (alm_ev && running && src_alm && cfg_reg.alm_cont)
        almrun_reg <= 1'b1;
      else if (!running)
        almrun_reg <= 1'b0;
    end
  end

  // RULE_13 bus trigger outside wait state is refused
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b)
      rej_reg <= 1'b0;
    else if (bus_p && (!in_wait || cfg_reg.src != STS_SRC_BUS))
      rej_reg <= 1'b1;
    else if (wr_cyc && widx == STS_A_STAT && avs_writedata[STS_S_REJ])
      rej_reg <= 1'b0;
  end

  wire [3:0] nxt = next_slot(list_reg, 4'(cur_reg) + 4'h1);
  wire [3:0] first = next_slot(list_reg, 4'h0);
  wire stored = st_reg == STS_MEAS && meas_done && !abort_p;
  wire done_cnt = !cont_reg && acc_reg == tcnt_reg;

  // Sweep sequencing
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_reg <= STS_IDLE;
      cur_reg <= 3'h0;
      req_reg <= 1'b0;
      int_reg <= 1'b0;
      abt_reg <= 1'b0;
      acc_reg <= 19'h0;
    end else begin
      req_reg <= 1'b0;
      abt_reg <= 1'b0;
      if (abort_p) begin
        // RULE_04 RULE_22 abort drops to idle, memory kept
        if (running)
          abt_reg <= 1'b1;
        st_reg <= STS_IDLE;
        int_reg <= 1'b0;
      end else begin
        unique case (st_reg)
          STS_IDLE: if (init_p) begin
            acc_reg <= 19'h0;
            st_reg <= STS_WAITT;
          end
          STS_WAITT: if (accept) begin
            acc_reg <= acc_reg + 19'h1;
            req_reg <= 1'b1;
            st_reg <= STS_MEAS;
            // RULE_03 empty list uses internal meter
            int_reg <= list_reg == 8'h00;
            // RULE_01 start at lowest listed slot
            cur_reg <= list_reg == 8'h00 ? 3'h0 : first[2:0];
          end
          STS_MEAS: if (meas_done) begin
            if (nxt[3] || int_reg) begin
              st_reg <= STS_FIN;
            end else begin
              // RULE_01 next listed slot ascending
              cur_reg <= nxt[2:0];
              req_reg <= 1'b1;
            end
          end
          // RULE_08 stop at trigger count
          STS_FIN: st_reg <= done_cnt ? STS_IDLE : STS_WAITT;
        endcase
      end
    end
  end

  // RULE_11 gain and offset scaling plus limit flag
  wire signed [31:0] prod = $signed(meas_data) * $signed(gain_reg);
  wire [15:0] scaled = prod[23:8] + offs_reg;
  sts_rd_type rd_new;
  assign rd_new = '{alarm: scaled > lim_reg, internal: int_reg, chan: cur_reg, value: scaled};

  always_ff @(posedge sys_clk) begin
    if (stored)
      mem[wptr_reg] <= rd_new;
  end

  // RULE_02 RULE_20 RULE_23 memory pointer and overflow
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      wptr_reg <= '0;
      mcnt_reg <= '0;
      ovf_reg <= 1'b0;
    end else if (stored) begin
      wptr_reg <= wptr_reg + 1'b1;
      if (mcnt_reg == (AW+1)'(DEPTH))
        ovf_reg <= 1'b1;
      else
        mcnt_reg <= mcnt_reg + 1'b1;
    end else if (init_p && !running) begin
      wptr_reg <= '0;
      mcnt_reg <= '0;
      ovf_reg <= 1'b0;
    end
  end

  logic scan_reg, waitt_reg;
  always_ff @(posedge sys_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      scan_reg <= 1'b0;
      waitt_reg <= 1'b0;
    end else begin
      scan_reg <= running;
      waitt_reg <= in_wait;
    end
  end

  assign avs_readdata = rdat_reg;
  assign avs_waitrequest = wait_reg;
  assign chan_req = req_reg;
  assign chan_sel = cur_reg;
  assign internal_meas = int_reg;
  assign meas_abort = abt_reg;
  assign scanning = scan_reg;
  assign waiting_trig = waitt_reg;
  assign first_alarm_output = alm_out_reg;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_sync_b);

  a_abort_to_idle: assert property (abort_p |=> st_reg == STS_IDLE && !req_reg) // RULE_04
    else $error("abort did not stop the scan");
  a_init_clears: assert property (init_p && !running |=> mcnt_reg == '0 && !ovf_reg) // RULE_02
    else $error("initiate left old readings");
  a_empty_internal: assert property (accept && list_reg == 8'h00 |=> req_reg && int_reg) // RULE_03
    else $error("empty list did not use internal meter");
  a_slot_listed: assert property (req_reg && !int_reg |-> list_reg[cur_reg]) // RULE_01
    else $error("unlisted slot requested");
  a_slot_ascend: assert property (req_reg && !int_reg && $past(st_reg) == STS_MEAS
    |-> cur_reg > $past(cur_reg)) // RULE_01
    else $error("slots out of order");
  a_ext_pending: assert property (ext_fall && running && src_ext |=> pend_reg) // RULE_19
    else $error("external trigger not held");
  a_bus_reject: assert property (bus_p && !in_wait |=> rej_reg) // RULE_13
    else $error("early bus trigger not refused");
  a_count_stop: assert property (st_reg == STS_FIN && done_cnt && !abort_p |=> st_reg == STS_IDLE) // RULE_08
    else $error("scan ran past trigger count");
  a_conf_force: assert property (conf_p |=> intv_reg == 29'h0 && tcnt_reg == 19'h1) // RULE_09
    else $error("configure did not force defaults");
  a_timer_hold: assert property (in_wait && src_ext == 1'b0 && cfg_reg.src == STS_SRC_TIMER
    && !timer_due && !abort_p |=> st_reg == STS_WAITT) // RULE_06
    else $error("timer fired before interval");
  a_overflow_flag: assert property (stored && mcnt_reg == (AW+1)'(DEPTH) |=> ovf_reg) // RULE_23
    else $error("overflow not flagged");

  c_ext_sweep: cover property (src_ext && accept ##[1:50] st_reg == STS_FIN);
  c_overflow: cover property (stored && mcnt_reg == (AW+1)'(DEPTH));
  c_abort_meas: cover property (st_reg == STS_MEAS && abort_p);
  c_alarm_sweep: cover property (src_alm && accept);
endmodule
`default_nettype wire

/* File: sts_meter_model.sv */
// Behavioural meter that answers each channel request after a fixed latency unless meas_abort cancels it first
`timescale 1ns/100ps
`default_nettype none
module sts_meter_model
  import sts_pkg::*;
#(
  parameter int LAT = 3
)(
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic        chan_req,
  input  wire logic [2:0]  chan_sel,
  input  wire logic        meas_abort,
  output logic             meas_done,
  output logic [15:0]      meas_data
);
  int         cnt;
  logic [2:0] sel;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt       <= 0;
      sel       <= 3'h0;
      meas_done <= 1'b0;
      meas_data <= 16'h0000;
    end else begin
      meas_done <= 1'b0;
      // Data line toggles when no reading is offered
      meas_data <= ~meas_data;
      if (chan_req) begin
        cnt <= LAT;
        sel <= chan_sel;
      end else if (meas_abort) begin
        cnt <= 0;
      end else if (cnt == 1) begin
        cnt       <= 0;
        meas_done <= 1'b1;
        meas_data <= 16'h0100 + 16'(sel);
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: sts_scan_trigger_sequencer_bench.sv */
// Self-checking bench for the scan trigger sequencer
`timescale 1ns/100ps
`default_nettype none
module sts_scan_trigger_sequencer_bench;
  import sts_pkg::*;
  logic        sys_clk = 0, rst_b = 0, avs_read = 0, avs_write = 0, ext_trig_b = 1;
  logic [5:0]  avs_address = 6'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
  logic        avs_waitrequest, meas_done, chan_req, internal_meas, meas_abort;
  logic        scanning, waiting_trig, first_alarm_output;
  logic [15:0] meas_data;
  logic        mon_valid = 0;
  logic [15:0] mon_data = 16'h0000;
  logic [2:0]  chan_sel;
  int          err_total = 0, total_checks = 0;
  sts_scan_trigger_sequencer #(.TICK_CYC(10)) u_sts_scan_trigger_sequencer (.sys_clk(sys_clk),
    .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_trig_b(ext_trig_b), .meas_done(meas_done), .meas_data(meas_data), .mon_valid(mon_valid),
    .mon_data(mon_data), .chan_req(chan_req), .chan_sel(chan_sel), .internal_meas(internal_meas),
    .meas_abort(meas_abort), .scanning(scanning), .waiting_trig(waiting_trig),
    .first_alarm_output(first_alarm_output));
  sts_meter_model u_sts_meter_model (.sys_clk(sys_clk), .rst_b(rst_b), .chan_req(chan_req),
    .chan_sel(chan_sel), .meas_abort(meas_abort), .meas_done(meas_done), .meas_data(meas_data));
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  function automatic logic [5:0] A(input logic [3:0] r);
    return {r, 2'b00};
  endfunction
  task automatic results();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
    if (n >= 50) begin
      err_total++;
      results();
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rc(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  task automatic wait_sig(input logic wt, input logic want);
    int n;
    for (n = 0; n < 2000 && (wt ? waiting_trig : scanning) !== want; n++) @(posedge sys_clk);
    if (n >= 2000) begin
      err_total++;
      results();
    end
  endtask
  task automatic t_reset();
    rc(A(STS_A_INTV), 32'hFFFFFFFF, 32'h0);
    rc(A(STS_A_TCNT), 32'h0007FFFF, 32'h1);
    rc(A(STS_A_SCALE), 32'hFFFFFFFF, 32'h00000100);
    rc(6'h2C, 32'hFFFFFFFF, 32'h0);
    $display("test reset values done");
  endtask
  task automatic t_sweep();
    logic [2:0] s;
    wr(A(STS_A_CFG), 32'(STS_SRC_SOFT));
    wr(A(STS_A_LIST), 32'h000000A4);
    wr(A(STS_A_TCNT), 32'h2);
    wr(A(STS_A_CTRL), 32'h1);
    wait_sig(1'b0, 1'b1);
    wait_sig(1'b0, 1'b0);
    rc(A(STS_A_MCNT), 32'hFF, 32'h6);
    for (int i = 0; i < 6; i++) begin
      s = (i % 3 == 0) ? 3'h2 : (i % 3 == 1) ? 3'h5 : 3'h7;
      wr(A(STS_A_MIDX), 32'(i));
      rc(A(STS_A_MDATA), 32'h000FFFFF, {13'h0, s, 16'h0100 + 16'(s)});
    end
    chk(32'(chan_sel), 32'h7);
    $display("test ordered sweeps done");
  endtask
  task automatic t_empty();
    wr(A(STS_A_LIST), 32'h0);
    wr(A(STS_A_TCNT), 32'h1);
    wr(A(STS_A_CTRL), 32'h1);
    wait_sig(1'b0, 1'b1);
    wait_sig(1'b0, 1'b0);
    rc(A(STS_A_MCNT), 32'hFF, 32'h1);
    wr(A(STS_A_MIDX), 32'h0);
    rc(A(STS_A_MDATA), 32'h00080000, 32'h00080000);
    chk(32'(internal_meas), 32'h1);
    $display("test empty list done");
  endtask
  task automatic t_bus();
    wr(A(STS_A_CFG), 32'(STS_SRC_BUS));
    wr(A(STS_A_LIST), 32'h1);
    wr(A(STS_A_TCNT), 32'h3);
    wr(A(STS_A_CTRL), 32'h4);
    rc(A(STS_A_STAT), 32'h10, 32'h10);
    wr(A(STS_A_STAT), 32'h10);
    wr(A(STS_A_CTRL), 32'h1);
    for (int i = 0; i < 2; i++) begin
      wait_sig(1'b1, 1'b1);
      wr(A(STS_A_CTRL), i ? 32'h4 : 32'h8);
      wait_sig(1'b1, 1'b0);
    end
    wait_sig(1'b1, 1'b1);
    rc(A(STS_A_STAT), 32'h10, 32'h0);
    wr(A(STS_A_CTRL), 32'h2);
    wait_sig(1'b0, 1'b0);
    wr(A(STS_A_CTRL), 32'h4);
    chk(32'(scanning), 32'h0);
    rc(A(STS_A_MCNT), 32'hFF, 32'h2);
    $display("test bus trigger and abort done");
  endtask
  task automatic t_ext();
    wr(A(STS_A_CFG), 32'(STS_SRC_EXT));
    wr(A(STS_A_LIST), 32'h3);
    wr(A(STS_A_CTRL), 32'h1);
    wait_sig(1'b1, 1'b1);
    // three short low pulses, two arrive mid sweep
    for (int i = 0; i < 3; i++) begin
      ext_trig_b <= 1'b0;
      repeat (3) @(posedge sys_clk);
      ext_trig_b <= 1'b1;
      repeat (2) @(posedge sys_clk);
    end
    // Long enough for the two accepted sweeps to finish
    repeat (80) @(posedge sys_clk);
    rc(A(STS_A_MCNT), 32'hFF, 32'h4);
    chk(32'(waiting_trig), 32'h1);
    wr(A(STS_A_CTRL), 32'h2);
    $display("test external trigger done");
  endtask
  task automatic t_conf();
    wr(A(STS_A_INTV), 32'h1FFFFFFF);
    rc(A(STS_A_INTV), 32'hFFFFFFFF, 32'(STS_INT_MAX_MS));
    wr(A(STS_A_CTRL), 32'hC0);
    rc(A(STS_A_INTV), 32'hFFFFFFFF, 32'(STS_INT_MAX_MS));
    wr(A(STS_A_CTRL), 32'h10);
    rc(A(STS_A_INTV), 32'hFFFFFFFF, 32'h0);
    rc(A(STS_A_TCNT), 32'h0007FFFF, 32'h1);
    $display("test configure command done");
  endtask
  task automatic t_timer();
    wr(A(STS_A_CFG), 32'(STS_SRC_TIMER));
    wr(A(STS_A_LIST), 32'h1);
    wr(A(STS_A_INTV), 32'h2);
    wr(A(STS_A_TCNT), 32'h2);
    wr(A(STS_A_CTRL), 32'h1);
    wait_sig(1'b0, 1'b1);
    wait_sig(1'b0, 1'b0);
    rc(A(STS_A_MCNT), 32'hFF, 32'h2);
    $display("test timer trigger done");
  endtask
  task automatic t_alarm();
    // Monitored slot 1, upper limit crossing, single sweep
    wr(A(STS_A_CFG), 32'h34);
    wr(A(STS_A_LIST), 32'h0203);
    wr(A(STS_A_LIM), 32'h50);
    wr(A(STS_A_TCNT), 32'h1);
    wr(A(STS_A_CTRL), 32'h1);
    wait_sig(1'b1, 1'b1);
    mon_valid <= 1'b1;
    mon_data  <= 16'h0040;
    @(posedge sys_clk);
    mon_data  <= 16'h0060;
    @(posedge sys_clk);
    mon_valid <= 1'b0;
    @(posedge sys_clk);
    chk(32'(first_alarm_output), 32'h1);
    wait_sig(1'b0, 1'b0);
    rc(A(STS_A_MCNT), 32'hFF, 32'h2);
    $display("test alarm trigger done");
  endtask
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_sweep();
    t_empty();
    t_bus();
    t_ext();
    t_conf();
    t_timer();
    t_alarm();
    results();
  end
endmodule
`default_nettype wire
